// File: src/anvmp_consts.vh
// Purpose: timing constants for the async memory port controller
// Assumes: 40 MHz mclk, 25 ns period
// Notes: all times round up to whole mclk cycles
`ifndef ANVMP_CONSTS_VH
`define ANVMP_CONSTS_VH
`define ANVMP_CLK_PERIOD_PS 25000
`define ANVMP_T_CYCLE_NS 35
`define ANVMP_T_ACCESS_NS 35
`define ANVMP_T_OE_ACCESS_NS 15
`define ANVMP_T_WP_NS 15
`define ANVMP_T_AV_END_NS 20
`define ANVMP_T_DATA_SETUP_NS 10
`define ANVMP_T_RECOVERY_NS 12
`define ANVMP_T_HIGH_NS 2
`define ANVMP_T_RELEASE_NS 15
`define ANVMP_T_STARTUP_NS 2000000
`define ANVMP_CYC_UP(ns) (((ns) * 1000 + `ANVMP_CLK_PERIOD_PS - 1) / `ANVMP_CLK_PERIOD_PS)
`endif

// File: src/anvmp_delay.v
// Purpose: loadable down counter that times pin phases
// Assumes: load and count share mclk
// Notes: done is high while the count is zero
module anvmp_delay #(
	parameter W = 8
) (
	input wire mclk,
	input wire rst_n,
	input wire load,
	input wire [W-1:0] value,
	output wire done
);
	reg [W-1:0] cnt_reg;
	// Count down to zero, reload on request
	always @(posedge mclk)
	begin
		if (!rst_n)
			cnt_reg <= {W{1'b0}};
		else if (load)
			cnt_reg <= value;
		else if (cnt_reg != {W{1'b0}})
			cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
	end
	assign done = (cnt_reg == {W{1'b0}});
endmodule // anvmp_delay

// File: src/anvmp_ctrl.v
// Purpose: host controller for a 256K x 16 async non-volatile memory
// Assumes: one request at a time, taken when req_ready is high
// Notes: every pin comes from a flip-flop; read data is synchronised
// What this block does
// - Write enable stays high during reads
// - Deasserted strobes stay high 2 ns
// - Enable falls spaced 35 ns apart
// - Write pulse 15 ns, address 20 ns
// - Data stable 10 ns before write end
// - Enable-ended write keeps same minimums
// - Address held 12 ns after write end
// - Strobes high for 2 ms startup
`include "anvmp_consts.vh"
module anvmp_ctrl #(
	parameter AW = 18,
	parameter DW = 16,
	parameter STARTUP_CYC = `ANVMP_CYC_UP(`ANVMP_T_STARTUP_NS)
) (
	input wire mclk,
	input wire rst_n,
	input wire req_valid,
	input wire req_write,
	input wire [AW-1:0] req_addr,
	input wire [DW-1:0] req_wdata,
	input wire [1:0] req_byte_en,
	output reg req_ready,
	output reg rsp_valid,
	output reg [DW-1:0] rsp_rdata,
	output reg chip_enable_n,
	output reg write_enable_n,
	output reg output_enable_n,
	output reg upper_byte_enable_n,
	output reg lower_byte_enable_n,
	output reg [AW-1:0] mem_addr,
	output reg [DW-1:0] mem_dq_out,
	output reg mem_dq_oe,
	input wire [DW-1:0] mem_dq_in
);
	localparam CW = 8;
	// Cycle counts worked out wide, then cut to the timer width
	localparam integer ACC_I = `ANVMP_CYC_UP(`ANVMP_T_ACCESS_NS) + 1;
	localparam integer WP_I = `ANVMP_CYC_UP(`ANVMP_T_AV_END_NS);
	localparam integer REC_I = `ANVMP_CYC_UP(`ANVMP_T_RECOVERY_NS);
	localparam integer REL_I = `ANVMP_CYC_UP(`ANVMP_T_RELEASE_NS);
	localparam integer CYC_I = `ANVMP_CYC_UP(`ANVMP_T_CYCLE_NS);
	localparam integer HI_I = `ANVMP_CYC_UP(`ANVMP_T_HIGH_NS);
	localparam [CW-1:0] C_ACC = ACC_I[CW-1:0];
	localparam [CW-1:0] C_WP = WP_I[CW-1:0];
	localparam [CW-1:0] C_REC = REC_I[CW-1:0];
	localparam [CW-1:0] C_REL = REL_I[CW-1:0];
	localparam [CW-1:0] C_CYC = CYC_I[CW-1:0];
	localparam [CW-1:0] C_HI = HI_I[CW-1:0];
	localparam [2:0] S_BOOT = 3'h0;
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_RD = 3'h2;
	localparam [2:0] S_WR = 3'h3;
	localparam [2:0] S_REC = 3'h4;
	localparam [2:0] S_GAP = 3'h5;
	localparam [2:0] S_RSP = 3'h6;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [31:0] boot_reg;
	reg [DW-1:0] dq_meta_reg;
	reg [DW-1:0] dq_sync_reg;
	reg [CW-1:0] gap_reg;
	reg dly_load;
	reg [CW-1:0] dly_value;
	wire dly_done;
	wire gap_done;

	anvmp_delay #(.W(CW)) u_delay (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(dly_load),
		.value(dly_value),
		.done(dly_done)
	);

	// Pin data passes two flops; the extra access cycle covers it
	always @(posedge mclk)
	begin
		dq_meta_reg <= mem_dq_in;
		dq_sync_reg <= dq_meta_reg;
	end

	// Startup hold after reset, strobes high meanwhile
	always @(posedge mclk)
	begin
		if (!rst_n)
			boot_reg <= 32'h0;
		else if (state_reg == S_BOOT)
			boot_reg <= boot_reg + 32'h1;
	end

	// Enable-fall to enable-fall spacing counter
	always @(posedge mclk)
	begin
		if (!rst_n)
			gap_reg <= 8'h0;
		else if (req_ready && req_valid)
			gap_reg <= C_CYC - 8'h1;
		else if (gap_reg != 8'h0)
			gap_reg <= gap_reg - 8'h1;
	end
	assign gap_done = (gap_reg == 8'h0);

	// Next state and phase timer loads
	always @*
	begin
		state_next = state_reg;
		dly_load = 1'b0;
		dly_value = 8'h0;
		case (state_reg)
			S_BOOT:
				if (boot_reg >= STARTUP_CYC)
					state_next = S_IDLE;
			S_IDLE:
				if (req_valid)
				begin
					dly_load = 1'b1;
					if (req_write)
					begin
						dly_value = C_WP;
						state_next = S_WR;
					end
					else
					begin
						dly_value = C_ACC;
						state_next = S_RD;
					end
				end
			S_RD:
				if (dly_done)
				begin
					dly_load = 1'b1;
					dly_value = C_REL;
					state_next = S_RSP;
				end
			S_WR:
				if (dly_done)
				begin
					dly_load = 1'b1;
					dly_value = C_REC;
					state_next = S_REC;
				end
			S_REC, S_RSP:
				if (dly_done)
				begin
					dly_load = 1'b1;
					dly_value = C_HI;
					state_next = S_GAP;
				end
			S_GAP:
				if (dly_done && gap_done)
					state_next = S_IDLE;
			default:
				state_next = S_BOOT;
		endcase
	end

	// Pin and handshake registers
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_reg <= S_BOOT;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= {DW{1'b0}};
			chip_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			upper_byte_enable_n <= 1'b1;
			lower_byte_enable_n <= 1'b1;
			mem_addr <= {AW{1'b0}};
			mem_dq_out <= {DW{1'b0}};
			mem_dq_oe <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			req_ready <= (state_next == S_IDLE);
			rsp_valid <= 1'b0;
			case (state_reg)
				S_IDLE:
					if (req_valid)
					begin
						// Address, data and strobes launch together
						mem_addr <= req_addr;
						chip_enable_n <= 1'b0;
						upper_byte_enable_n <= ~req_byte_en[1];
						lower_byte_enable_n <= ~req_byte_en[0];
						if (req_write)
						begin
							write_enable_n <= 1'b0;
							output_enable_n <= 1'b1;
							mem_dq_out <= req_wdata;
							mem_dq_oe <= 1'b1;
						end
						else
						begin
							write_enable_n <= 1'b1;
							output_enable_n <= 1'b0;
							mem_dq_oe <= 1'b0;
						end
					end
				S_RD:
					if (dly_done)
					begin
						// Sample only after access plus sync delay
						rsp_rdata <= dq_sync_reg;
						rsp_valid <= 1'b1;
						chip_enable_n <= 1'b1;
						output_enable_n <= 1'b1;
						upper_byte_enable_n <= 1'b1;
						lower_byte_enable_n <= 1'b1;
					end
				S_WR:
					if (dly_done)
					begin
						// Both strobes rise; data and address held on
						write_enable_n <= 1'b1;
						chip_enable_n <= 1'b1;
						upper_byte_enable_n <= 1'b1;
						lower_byte_enable_n <= 1'b1;
					end
				S_REC:
					if (dly_done)
						mem_dq_oe <= 1'b0;
				default:
					mem_dq_oe <= mem_dq_oe;
			endcase
		end
	end
endmodule // anvmp_ctrl

// File: verif/anvmp_monitor.sv
// Purpose: pin timing checks on the memory controller
// Assumes: 25 ns clock, two cycles cover each ns minimum
// Notes: bound to anvmp_ctrl
module anvmp_monitor (
	input wire mclk,
	input wire rst_n,
	input wire req_ready,
	input wire chip_enable_n,
	input wire write_enable_n,
	input wire output_enable_n,
	input wire [17:0] mem_addr,
	input wire [15:0] mem_dq_out,
	input wire mem_dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic up_reg;
	// Set once the startup wait is over
	always @(posedge mclk)
		up_reg <= rst_n && (up_reg || req_ready);
	a_startup_quiet: assert property (
		!up_reg |-> chip_enable_n && write_enable_n) else $error("startup");
	a_read_we_high: assert property (
		!output_enable_n |-> write_enable_n && !mem_dq_oe) else $error("read");
	a_write_both: assert property (
		!write_enable_n |-> !chip_enable_n) else $error("write strobes");
	a_high_hold: assert property (
		$rose(chip_enable_n) |=> chip_enable_n) else $error("high hold");
	a_we_pulse: assert property (
		$fell(write_enable_n) |=> !write_enable_n ##1 write_enable_n)
		else $error("write pulse");
	a_enable_space: assert property (
		$fell(chip_enable_n) |=> !chip_enable_n ##1 !$fell(chip_enable_n))
		else $error("enable spacing");
	a_addr_steady: assert property (
		!$past(write_enable_n) |-> $stable(mem_addr)) else $error("address");
	a_data_setup: assert property (
		$rose(write_enable_n) |-> mem_dq_oe && $stable(mem_dq_out) ##1 mem_dq_oe)
		else $error("write data");
	cover property ($rose(write_enable_n));
	cover property ($fell(output_enable_n));
	cover property ($rose(up_reg));
endmodule // anvmp_monitor
bind anvmp_ctrl anvmp_monitor u_mon (.mclk, .rst_n, .req_ready,
	.chip_enable_n, .write_enable_n, .output_enable_n, .mem_addr,
	.mem_dq_out, .mem_dq_oe);

// File: verif/anvmp_mem_model.sv
// Purpose: behavioural async memory on the controller pins
// Assumes: acc_ns set by the bench to 5 or 35
// Notes: released bus inverts its value 3 ns after each change of rd, address or a byte enable, so can show the old word again
module anvmp_mem_model (
	input wire chip_enable_n,
	input wire write_enable_n,
	input wire output_enable_n,
	input wire upper_byte_enable_n,
	input wire lower_byte_enable_n,
	input wire [17:0] mem_addr,
	input wire [15:0] mem_dq_out,
	output logic [15:0] mem_dq_in = 16'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	int acc_ns = 35;
	logic [15:0] arr [0:262143];
	wire rd = !chip_enable_n && !output_enable_n && write_enable_n;
	wire wr_on = !chip_enable_n && !write_enable_n;
	// Store once the overlap settles, so same-edge pin updates are all in
	always @(posedge wr_on)
	begin
		#1;
		if (wr_on)
		begin
			if (!upper_byte_enable_n)
				arr[mem_addr][15:8] = mem_dq_out[15:8];
			if (!lower_byte_enable_n)
				arr[mem_addr][7:0] = mem_dq_out[7:0];
		end
	end
	// Off lanes read inverted so a lane slip shows
	always @(rd, mem_addr, upper_byte_enable_n, lower_byte_enable_n)
		if (rd)
			mem_dq_in <= #(acc_ns) arr[mem_addr] ^
				{{8{upper_byte_enable_n}}, {8{lower_byte_enable_n}}};
		else
			mem_dq_in <= #3 ~mem_dq_in;
endmodule // anvmp_mem_model

// File: verif/testbench.sv
// Purpose: self-checking bench for the async memory controller
// Assumes: startup shortened to 20 cycles
// Notes: reads compared on enabled byte lanes only
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, req_valid, req_write;
	logic [17:0] req_addr;
	logic [15:0] req_wdata;
	logic [1:0] req_byte_en;
	wire req_ready, rsp_valid, chip_enable_n, write_enable_n, output_enable_n;
	wire upper_byte_enable_n, lower_byte_enable_n, mem_dq_oe;
	wire [15:0] rsp_rdata, mem_dq_out, mem_dq_in;
	wire [17:0] mem_addr;
	logic [15:0] sh [0:7];
	logic [31:0] q [$];
	logic [31:0] e, r;
	int n_errors, n_tests, cyc, boot_cyc;
	integer seed = 32'h966C1A95;
	anvmp_ctrl #(.STARTUP_CYC(20)) DUT (.mclk, .rst_n, .req_valid, .req_write,
		.req_addr, .req_wdata, .req_byte_en, .req_ready, .rsp_valid, .rsp_rdata,
		.chip_enable_n, .write_enable_n, .output_enable_n, .upper_byte_enable_n,
		.lower_byte_enable_n, .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
	anvmp_mem_model mdl (.chip_enable_n, .write_enable_n, .output_enable_n,
		.upper_byte_enable_n, .lower_byte_enable_n, .mem_addr, .mem_dq_out,
		.mem_dq_in);
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Held from a falling edge until taken; notes the answer
	task automatic xfer(input logic w, input logic [2:0] k,
		input logic [15:0] d, input logic [1:0] be);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}};
		@(negedge mclk);
		while (req_ready !== 1'b1)
			@(negedge mclk);
		mdl.acc_ns = d[0] ? 5 : 35;
		req_valid = 1'b1;
		req_write = w;
		req_addr = {{15{k[2]}}, k};
		req_wdata = d;
		req_byte_en = be;
		if (w)
			sh[k] = sh[k] & ~m | d & m;
		else
			q.push_back({m, sh[k] & m});
		@(negedge mclk);
		req_valid = 1'b0;
	endtask
	// Oldest note against each answer; cycle cap cuts a hang
	always @(negedge mclk)
	begin
		cyc++;
		if (cyc > 4000)
		begin
			n_errors++;
			tally_and_finish;
		end
		if (rsp_valid === 1'b1)
		begin
			n_tests++;
			if (q.size() == 0)
			begin
				n_errors++;
				$display("BAD rsp_valid exp %0d got %0d", 0, 1);
			end
			else
			begin
				e = q.pop_front();
				if ((rsp_rdata & e[31:16]) !== e[15:0])
				begin
					n_errors++;
					$display("BAD rsp_rdata exp %h got %h", e[15:0], rsp_rdata);
				end
			end
		end
	end
	initial
	begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 18'h0;
		req_wdata = 16'h0;
		req_byte_en = 2'h0;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		for (int k = 0; k < 8; k++)
			xfer(1'b1, k[2:0], 16'($random(seed)), 2'h3);
		for (int i = 0; i < 60; i++)
		begin
			r = $random(seed);
			xfer(r[20], r[18:16], r[15:0], r[22:21]);
		end
		while (q.size() != 0 || req_ready !== 1'b1)
			@(negedge mclk);
		rst_n = 1'b0;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		// Early read must wait out the startup hold
		req_valid = 1'b1;
		req_write = 1'b0;
		req_addr = 18'h0;
		req_byte_en = 2'h3;
		q.push_back({16'hFFFF, sh[0]});
		boot_cyc = 0;
		while (req_ready !== 1'b1)
		begin
			@(negedge mclk);
			boot_cyc++;
		end
		n_tests++;
		if (boot_cyc != 21)
		begin
			n_errors++;
			$display("BAD boot_cyc exp %0d got %0d", 21, boot_cyc);
		end
		@(negedge mclk);
		req_valid = 1'b0;
		for (int k = 0; k < 8; k++)
			xfer(1'b0, k[2:0], 16'h0, 2'h3);
		repeat (20) @(negedge mclk);
		tally_and_finish;
	end
endmodule // testbench
